/* hw/clcr_chip_config.v */
// Purpose: Chip-level global configuration register bank
// Assumes: Host strobes are one-cycle pulses synchronous to clk
// Notes:   Per-device registers live outside; this block exports selection
//          Soft reset is a one-clock pulse; per-device registers reload on it
//
// Summary of operation
// - Global registers occupy indices 0x00 to 0x2F.
// - All eight index bits are decoded; no aliasing.
// - Unimplemented registers and bits ignore writes, read zero.
// - Host writes index port first; device latches it as selection.
// - Data port accesses act on the latched selected register.
// - Global registers respond only while configuration mode is active.
// - Writing one to bit 0 at 0x02 soft-resets; bit self-clears.
// - Bit 7 at 0x03 enables watchdog and system management interrupt access.
// - Bits 1:0 at 0x03 pick run index port E0/E2/E4/EA.
// - Writing 0x07 selects the logical device for per-device access.
// - Activate command affects only the selected logical device.
`timescale 1ns/100ps
`include "clcr_consts.vh"
`default_nettype none

module clcr_chip_config #(
    parameter NUM_LDEV = 16
) (
    input  wire                clk,
    input  wire                rst,
    input  wire                configMode,
    input  wire                indexWrite,
    input  wire                dataWrite,
    input  wire                dataRead,
    input  wire [7:0]          hostWrData,
    output wire [7:0]          hostRdData,
    output wire                hostRdValid,
    output wire [7:0]          selectedIndex,
    output wire [7:0]          logicalDevice,
    output wire [7:0]          runIndexPortAddr,
    output wire                altAccessEnable,
    output wire                softResetPulse,
    output wire [NUM_LDEV-1:0] activateWrite,
    output wire [7:0]          activateData
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Exact match on all index bits for the write paths; the read path
    // matches the full index in readMux, so no upper-bit alias can creep in
    function isIndex;
        input [7:0] idx;
        input [7:0] target;
        begin
            isIndex = (idx == target);
        end
    endfunction

    // Global window is the low part of the index space
    function isGlobal;
        input [7:0] idx;
        begin
            isGlobal = (idx <= `CLCR_IDX_GLOBAL_LAST);
        end
    endfunction

    // Read value of the selected global register; anything that holds
    // no state answers zero
    function [7:0] readMux;
        input [7:0] idx;
        input [7:0] runIdx;
        input [7:0] ldev;
        begin
            case (idx)
                `CLCR_IDX_CFG_CTRL: begin
                    readMux = 8'h00;
                end
                `CLCR_IDX_RUN_IDX_SEL: begin
                    readMux = runIdx;
                end
                `CLCR_IDX_LDEV_SEL: begin
                    readMux = ldev;
                end
                default: begin
                    readMux = 8'h00;
                end
            endcase
        end
    endfunction

    // Run-mode address of the general-purpose index port
    function [7:0] gpiAddr;
        input [1:0] sel;
        begin
            case (sel)
                2'b00: begin
                    gpiAddr = `CLCR_GPI_ADDR_00;
                end
                2'b01: begin
                    gpiAddr = `CLCR_GPI_ADDR_01;
                end
                2'b10: begin
                    gpiAddr = `CLCR_GPI_ADDR_10;
                end
                default: begin
                    gpiAddr = `CLCR_GPI_ADDR_11;
                end
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Registered outputs; every pulse stands exactly one clock
    reg  [7:0]          index_ff;
    reg  [7:0]          runIdx_ff;
    reg  [7:0]          ldev_ff;
    reg  [7:0]          rdData_ff;
    reg                 rdValid_ff;
    reg                 softRst_ff;
    reg  [7:0]          actData_ff;
    reg  [NUM_LDEV-1:0] actWrite_ff;

    // Next-state values, set combinationally; nxt_actWrite by one assign per device
    reg  [7:0]          nxt_index;
    reg  [7:0]          nxt_runIdx;
    reg  [7:0]          nxt_ldev;
    reg  [7:0]          nxt_rdData;
    reg                 nxt_rdValid;
    reg  [7:0]          nxt_actData;
    wire [NUM_LDEV-1:0] nxt_actWrite;

    // ------------------------------------------------------------
    // Host strobe qualification
    // ------------------------------------------------------------
    // Nothing is taken outside configuration mode, not even the index
    wire idxWr = indexWrite & configMode;
    wire wrCfg = dataWrite & configMode;
    wire rdCfg = dataRead & configMode;

    // Index hits for the write paths and the read window check; readMux decodes the read index itself
    wire hitCfgCtrl  = isIndex(index_ff, `CLCR_IDX_CFG_CTRL);
    wire hitRunIdx   = isIndex(index_ff, `CLCR_IDX_RUN_IDX_SEL);
    wire hitLdev     = isIndex(index_ff, `CLCR_IDX_LDEV_SEL);
    wire hitActivate = isIndex(index_ff, `CLCR_IDX_ACTIVATE);
    wire hitGlobal   = isGlobal(index_ff);

    // Config-control holds no state: the write becomes a pulse only,
    // which is what makes the soft-reset bit clear itself
    wire softRst = wrCfg & hitCfgCtrl
                   & hostWrData[`CLCR_BIT_SOFT_RESET];

    // ------------------------------------------------------------
    // Index latch
    // ------------------------------------------------------------
    // The index is kept across a soft reset so the host is not lost
    always @* begin
        nxt_index = index_ff;
        if (idxWr) begin
            nxt_index = hostWrData;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            index_ff <= `CLCR_RST_INDEX;
        end else begin
            index_ff <= nxt_index;
        end
    end

    // ------------------------------------------------------------
    // Run-mode index address select
    // ------------------------------------------------------------
    // Soft reset wins over a data write in the same cycle
    always @* begin
        nxt_runIdx = runIdx_ff;
        if (softRst) begin
            nxt_runIdx = `CLCR_SOFT_RUN_IDX_SEL;
        end else if (wrCfg & hitRunIdx) begin
            // Reserved bits 6:2 are masked so they always read zero
            nxt_runIdx = hostWrData & `CLCR_RUN_IDX_MASK;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            runIdx_ff <= `CLCR_RST_RUN_IDX_SEL;
        end else begin
            runIdx_ff <= nxt_runIdx;
        end
    end

    // ------------------------------------------------------------
    // Logical device select
    // ------------------------------------------------------------
    // The number is stored whole, even one with no device behind it
    always @* begin
        nxt_ldev = ldev_ff;
        if (softRst) begin
            nxt_ldev = `CLCR_SOFT_LDEV_SEL;
        end else if (wrCfg & hitLdev) begin
            nxt_ldev = hostWrData;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ldev_ff <= `CLCR_RST_LDEV_SEL;
        end else begin
            ldev_ff <= nxt_ldev;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Indices above the global window are left unanswered so that the
    // per-device logic can drive the data port instead
    always @* begin
        nxt_rdValid = 1'b0;
        nxt_rdData  = 8'h00;
        if (rdCfg & hitGlobal) begin
            nxt_rdValid = 1'b1;
            nxt_rdData  = readMux(index_ff, runIdx_ff, ldev_ff);
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rdValid_ff <= 1'b0;
            rdData_ff  <= 8'h00;
        end else begin
            rdValid_ff <= nxt_rdValid;
            rdData_ff  <= nxt_rdData;
        end
    end

    // ------------------------------------------------------------
    // Soft reset pulse
    // ------------------------------------------------------------
    // One clock wide; the per-device registers reload on it
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            softRst_ff <= 1'b0;
        end else begin
            softRst_ff <= softRst;
        end
    end

    // ------------------------------------------------------------
    // Activate routing
    // ------------------------------------------------------------
    // Data goes to every device, but the write strobe only to the one
    // selected; a device number beyond NUM_LDEV reaches nobody
    always @* begin
        nxt_actData = 8'h00;
        if (wrCfg) begin
            nxt_actData = hostWrData;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_LDEV; g = g + 1) begin : gen_act
            // Each device compares the stored number against its own
            localparam [7:0] DEV_NUM = g;
            assign nxt_actWrite[g] = wrCfg & hitActivate
                                     & (ldev_ff == DEV_NUM);
        end
    endgenerate

    // Registered so every device sees strobe and data in one cycle
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            actWrite_ff <= {NUM_LDEV{1'b0}};
            actData_ff  <= 8'h00;
        end else begin
            actWrite_ff <= nxt_actWrite;
            actData_ff  <= nxt_actData;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Pulses and read data all come straight from flip-flops
    assign hostRdData       = rdData_ff;
    assign hostRdValid      = rdValid_ff;
    assign selectedIndex    = index_ff;
    assign logicalDevice    = ldev_ff;

    // Only bits 1:0 steer the run-mode port address
    assign runIndexPortAddr = gpiAddr(runIdx_ff[1:0]);
    // This block only reports the enable; the gated registers sit in
    // the per-device logic, which must honour it
    assign altAccessEnable  = runIdx_ff[`CLCR_BIT_ALT_ACCESS];
    assign softResetPulse   = softRst_ff;
    assign activateWrite    = actWrite_ff;
    assign activateData     = actData_ff;

endmodule

`default_nettype wire

/* hw/clcr_consts.vh */
// Purpose: Constants for the chip-level configuration register bank
// Assumes: 8-bit index and data ports
// Notes:   Definitions only
`ifndef CLCR_CONSTS_VH
`define CLCR_CONSTS_VH

// ------------------------------------------------------------
// Register indices
// ------------------------------------------------------------
`define CLCR_IDX_CFG_CTRL     8'h02
`define CLCR_IDX_RUN_IDX_SEL  8'h03
`define CLCR_IDX_LDEV_SEL     8'h07
`define CLCR_IDX_GLOBAL_LAST  8'h2F
`define CLCR_IDX_ACTIVATE     8'h30

// ------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------
`define CLCR_BIT_SOFT_RESET   0
`define CLCR_BIT_ALT_ACCESS   7
`define CLCR_RUN_IDX_MASK     8'h83
`define CLCR_RST_INDEX        8'h00
`define CLCR_RST_CFG_CTRL     8'h00
`define CLCR_RST_RUN_IDX_SEL  8'h03
`define CLCR_RST_LDEV_SEL     8'h00
`define CLCR_SOFT_RUN_IDX_SEL 8'h03
`define CLCR_SOFT_LDEV_SEL    8'h00

// ------------------------------------------------------------
// Run-mode general-purpose index port addresses
// ------------------------------------------------------------
`define CLCR_GPI_ADDR_00      8'hE0
`define CLCR_GPI_ADDR_01      8'hE2
`define CLCR_GPI_ADDR_10      8'hE4
`define CLCR_GPI_ADDR_11      8'hEA

`endif

/* test/clcr_chk.sv */
// Purpose: Port checks for the chip-level register bank
// Assumes: One clock, rst async high
// Notes:   Bound to every instance
`timescale 1ns/100ps
`default_nettype none
module clcr_chk #(parameter NUM_LDEV = 16) (
    input wire clk, rst, configMode, indexWrite, dataWrite, dataRead,
    input wire hostRdValid, altAccessEnable, softResetPulse,
    input wire [7:0] hostWrData, hostRdData, selectedIndex,
    input wire [7:0] logicalDevice, runIndexPortAddr, activateData,
    input wire [NUM_LDEV-1:0] activateWrite);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire wr = dataWrite && configMode;
    wire rd = dataRead && configMode;
    idx_latch_a: assert property (indexWrite && configMode
        |=> selectedIndex == $past(hostWrData)) else $error("index");
    rd_answer_a: assert property (rd && selectedIndex <= 8'h2F
        |=> hostRdValid) else $error("no answer");
    cfg_gate_a: assert property (!configMode
        |=> !hostRdValid && !softResetPulse) else $error("gated");
    ldev_wr_a: assert property (wr && selectedIndex == 8'h07
        |=> logicalDevice == $past(hostWrData)) else $error("ldev");
    soft_rst_a: assert property (wr && selectedIndex == 8'h02
        && hostWrData[0] |=> softResetPulse && logicalDevice == 8'h00
        && runIndexPortAddr == 8'hEA) else $error("soft reset");
    cc_zero_a: assert property (rd && selectedIndex == 8'h02
        |=> hostRdData == 8'h00) else $error("ctrl read");
    gp_addr_a: assert property (wr && selectedIndex == 8'h03
        |=> altAccessEnable == $past(hostWrData[7]) && runIndexPortAddr ==
        ($past(hostWrData[1:0]) == 2'h3 ? 8'hEA
        : 8'hE0 + {$past(hostWrData[1:0]), 1'b0})) else $error("gp");
    act_one_a: assert property (wr && selectedIndex == 8'h30
        && logicalDevice < NUM_LDEV
        |=> activateWrite == 1 << $past(logicalDevice)) else $error("act");
    act_data_a: assert property (wr
        |=> activateData == $past(hostWrData)) else $error("act data");
endmodule
bind clcr_chip_config clcr_chk #(.NUM_LDEV(NUM_LDEV)) chk (.*);
`default_nettype wire

/* test/clcr_host.sv */
// Purpose: Host model making index and data port cycles
// Assumes: Strobes are one-cycle pulses
// Notes:   Idle write data shows the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module clcr_host (input wire clk, input wire hostRdValid,
    input wire [7:0] hostRdData, output reg configMode = 1'b0,
    output reg indexWrite = 1'b0, output reg dataWrite = 1'b0,
    output reg dataRead = 1'b0, output reg [7:0] hostWrData = 8'h00);
    task mode(input m);
        @(posedge clk) configMode <= m;
    endtask
    task acc(input [7:0] i, input [7:0] d, input w, output [8:0] r);
        begin
            @(posedge clk) indexWrite <= 1'b1;
            hostWrData <= i;
            @(posedge clk) indexWrite <= 1'b0;
            dataWrite <= w;
            dataRead <= !w;
            hostWrData <= d;
            @(posedge clk) dataWrite <= 1'b0;
            dataRead <= 1'b0;
            hostWrData <= ~d;
            @(negedge clk) r = {hostRdValid, hostRdData};
        end
    endtask
endmodule
`default_nettype wire

/* test/clcr_chip_config_tb_top.sv */
// Purpose: Directed register tests for the bank
// Assumes: 100 MHz clock, rst held 12 cycles
// Notes:   Each case writes a register, then reads it back
`timescale 1ns/100ps
`default_nettype none
module clcr_chip_config_tb_top;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [8:0] r;
    integer fail_count = 0, tests_run = 0, cyc = 0, k;
    wire cm, iw, dw, dr, rv, ae, sp;
    wire [7:0] wd, rd, si, ld, ga, ad;
    wire [15:0] aw;
    reg [15:0] actSeen = 16'h0000;
    reg [7:0] actDat = 8'h00;
    clcr_chip_config dut (.clk(clk), .rst(rst), .configMode(cm),
        .indexWrite(iw), .dataWrite(dw), .dataRead(dr), .hostWrData(wd),
        .hostRdData(rd), .hostRdValid(rv), .selectedIndex(si),
        .logicalDevice(ld), .runIndexPortAddr(ga), .altAccessEnable(ae),
        .softResetPulse(sp), .activateWrite(aw), .activateData(ad));
    clcr_host host (.clk(clk), .hostRdValid(rv), .hostRdData(rd),
        .configMode(cm), .indexWrite(iw), .dataWrite(dw),
        .dataRead(dr), .hostWrData(wd));
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (aw != 16'h0000) begin
            actSeen <= actSeen | aw;
            actDat <= ad;
        end
        if (cyc == 1000) begin
            fail_count = fail_count + 1;
            close_out;
        end
    end
    task chk(input string n, input [15:0] e, input [15:0] g);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                fail_count = fail_count + 1;
                $display("BAD %s exp %h got %h", n, e, g);
            end
        end
    endtask
    task rw(input [7:0] i, input [7:0] d, input [8:0] e);
        begin
            host.acc(i, d, 1'b1, r);
            host.acc(i, d, 1'b0, r);
            chk($sformatf("reg %h", i), e, r);
        end
    endtask
    task close_out;
        begin
            $display("fails %0d of %0d checks", fail_count, tests_run);
            if (fail_count == 0 && tests_run > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        host.mode(1'b1);
        chk("gp addr", 8'hEA, ga);
        chk("ldev", 8'h00, ld);
        rw(8'h07, 8'h05, 9'h105);
        rw(8'h05, 8'hFF, 9'h100);
        rw(8'h03, 8'hFC, 9'h180);
        rw(8'h83, 8'h01, 9'h000);
        chk("alt", 1'b1, ae);
        for (k = 3; k >= 0; k = k - 1) begin
            rw(8'h03, k, 9'h100 + k);
            chk("gp addr", k == 3 ? 8'hEA : 8'hE0 + 2 * k, ga);
        end
        rw(8'h30, 8'h01, 9'h000);
        chk("act strobe", 16'h0020, actSeen);
        chk("act data", 8'h01, actDat);
        rw(8'h07, 8'h09, 9'h109);
        rw(8'h02, 8'h01, 9'h100);
        chk("ldev", 8'h00, ld);
        chk("gp addr", 8'hEA, ga);
        host.mode(1'b0);
        rw(8'h07, 8'h06, 9'h000);
        chk("ldev", 8'h00, ld);
        host.mode(1'b1);
        rw(8'h07, 8'h0A, 9'h10A);
        rw(8'h03, 8'h80, 9'h180);
        chk("alt", 1'b1, ae);
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk("ldev", 8'h00, ld);
        chk("gp addr", 8'hEA, ga);
        chk("alt", 1'b0, ae);
        rw(8'h07, 8'h03, 9'h103);
        close_out;
    end
endmodule
`default_nettype wire
